// ---- hw/cfo_cfg.svh ----
// Constants for the FIFO timing-mode and flag-offset setup block.
//------------------------------------------------------------------
// Summary of operation
// - Timing pin high one clock after master reset release selects standard timing.
// - Standard timing uses empty/full flags; every word needs an explicit read.
// - Timing pin low one clock after master reset release selects fall-through timing.
// - Fall-through uses ready flags; first word into empty FIFO appears unread.
// - Four offsets kept: two for the first FIFO, two for the second.
// - Flag-select pins act the same in both timing modes.
// - Reset release with preset select codes loads 64, 16, 8, 256 or 1024.
// - Select code low-high-low at both resets rising picks serial loading.
// - Both resets with two low selects picks parallel; top select picks parity.
// - First four port A writes load offsets in fixed order, not memory.
// - Plain parity takes offset from contiguous port A bits from bit 0.
// - Interspersed parity takes bits 7..0 and 9 upward, skipping bit 8.
// - After four parallel loads port C input flag rises; normal operation starts.
// - Interspersed parity setup allows only parallel loading, never serial.
// - Serial: one bit per clock while enable low, MSB first, same order.
// - Port A input flag stays low until last serial bit, then rises.
//------------------------------------------------------------------
`ifndef CFO_CFG_SVH
`define CFO_CFG_SVH
// Select codes {fs2, fs1, fs0}.
`define CFO_SEL_P64    3'b111
`define CFO_SEL_P16    3'b110
`define CFO_SEL_P8     3'b101
`define CFO_SEL_P256   3'b011
`define CFO_SEL_P1024  3'b001
`define CFO_SEL_SERIAL 3'b010
`define CFO_SEL_PAR    3'b100
`define CFO_SEL_PARIP  3'b000
// Preset offset values.
`define CFO_VAL_P64    64
`define CFO_VAL_P16    16
`define CFO_VAL_P8     8
`define CFO_VAL_P256   256
`define CFO_VAL_P1024  1024
// Offset width for the deepest memory, and number of offset registers.
`define CFO_OFS_W      13
`define CFO_NUM_OFS    4
// Parity bit skipped in interspersed parity.
`define CFO_PARITY_BIT 8
`endif

// ---- hw/cfo_pkg.sv ----
// Types for the FIFO timing-mode and flag-offset setup block.
package cfo_pkg;
  typedef enum logic [1:0] {CFO_M_PRESET, CFO_M_SERIAL, CFO_M_PAR, CFO_M_PARIP} cfo_method_t;
  typedef enum logic [1:0] {CFO_S_RESET, CFO_S_LOAD, CFO_S_RUN} cfo_state_t;
  typedef struct packed {
    logic fall_through1;
    logic fall_through2;
    logic interleaved_parity_setup;
    logic serial_setup;
    logic parallel_setup;
  } cfo_mode_t;
endpackage : cfo_pkg

// ---- hw/cfo_setup.sv ----
// Reset-time timing-mode select and flag-offset loader for the dual FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "cfo_cfg.svh"
module cfo_setup #(
  parameter int OFS_W = `CFO_OFS_W
) (
  // Clock (port A clock) and synchronous reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Port C clock rising-edge strobe.
  input  wire logic              recv_clk_en,
  // Master resets and setup pins.
  input  wire logic              first_fifo_full_reset_n,
  input  wire logic              second_fifo_full_reset_n,
  input  wire logic              byte_order_timing_select,
  input  wire logic              flag_select2,
  input  wire logic              flag_select1_serial_enable_n,
  input  wire logic              flag_select0_serial_data,
  // Port A write qualifiers and data.
  input  wire logic              port_a_sel_n,
  input  wire logic              port_a_write,
  input  wire logic              port_a_enable,
  input  wire logic              port_a_mailbox,
  input  wire logic              port_a_full_n,
  input  wire logic [35:0]       port_a_data,
  // Offsets, mode and readiness toward the FIFO cores.
  output logic [OFS_W-1:0]       port_b_almost_empty_offset,
  output logic [OFS_W-1:0]       port_a_almost_full_offset,
  output logic [OFS_W-1:0]       port_a_almost_empty_offset,
  output logic [OFS_W-1:0]       port_c_almost_full_offset,
  output cfo_pkg::cfo_mode_t     mode,
  output logic                   first_fifo_cfg_ready,
  output logic                   second_fifo_cfg_ready,
  output logic                   offset_write_steal
);
  localparam int TOT_W = `CFO_NUM_OFS * OFS_W;
  localparam int CNT_W = $clog2(TOT_W + 1);

  //------------------------------------------------------------------
  // Decoding
  //------------------------------------------------------------------
  // Preset lookup, shared by both master resets.
  function automatic logic [OFS_W:0] preset_val(input logic [2:0] code);
    logic [OFS_W:0] r;
    r = '0;
    case (code)
      `CFO_SEL_P64:   r = {1'b1, OFS_W'(`CFO_VAL_P64)};
      `CFO_SEL_P16:   r = {1'b1, OFS_W'(`CFO_VAL_P16)};
      `CFO_SEL_P8:    r = {1'b1, OFS_W'(`CFO_VAL_P8)};
      `CFO_SEL_P256:  r = {1'b1, OFS_W'(`CFO_VAL_P256)};
      `CFO_SEL_P1024: r = {1'b1, OFS_W'(`CFO_VAL_P1024)};
      default:        r = '0;
    endcase
    return r;
  endfunction : preset_val

  //------------------------------------------------------------------
  // State
  //------------------------------------------------------------------
  logic                 first_fifo_full_reset_n_q_reg, second_fifo_full_reset_n_q_reg;
  logic                 pend1_reg, pend1_next, pend2_reg, pend2_next;
  logic                 fwft1_reg, fwft1_next, fwft2_reg, fwft2_next;
  cfo_pkg::cfo_method_t method_reg, method_next;
  cfo_pkg::cfo_state_t  state_reg, state_next;
  logic [TOT_W-1:0]     ofs_reg, ofs_next;
  logic [CNT_W-1:0]     cnt_reg, cnt_next;
  logic                 rdy1_reg, rdy1_next, rdy2_reg, rdy2_next;
  logic                 rise1, rise2, wr_q, par_mode, shift_en;
  logic [2:0]           sel;
  logic [OFS_W:0]       pv;
  logic [OFS_W-1:0]     par_word;

  assign rise1 = first_fifo_full_reset_n & ~first_fifo_full_reset_n_q_reg;
  assign rise2 = second_fifo_full_reset_n & ~second_fifo_full_reset_n_q_reg;
  assign sel   = {flag_select2, flag_select1_serial_enable_n, flag_select0_serial_data};
  assign pv    = preset_val(sel);
  // Ordinary first FIFO write qualification, including the full flag.
  assign wr_q  = ~port_a_sel_n & port_a_write & port_a_enable & ~port_a_mailbox & port_a_full_n;
  assign par_mode = (method_reg == cfo_pkg::CFO_M_PAR) || (method_reg == cfo_pkg::CFO_M_PARIP);
  // Serial shifting exists only for the serial method, never with interspersed parity.
  assign shift_en = (state_reg == cfo_pkg::CFO_S_LOAD) && (method_reg == cfo_pkg::CFO_M_SERIAL)
                    && !flag_select1_serial_enable_n;

  // Offset word from port A; interspersed parity drops the parity bit.
  always_comb
  begin
    if (method_reg == cfo_pkg::CFO_M_PARIP)
      par_word = {port_a_data[OFS_W:`CFO_PARITY_BIT+1], port_a_data[`CFO_PARITY_BIT-1:0]};
    else
      par_word = port_a_data[OFS_W-1:0];
  end

  // While parallel loading, qualified writes go to offsets instead of memory.
  assign offset_write_steal = (state_reg == cfo_pkg::CFO_S_LOAD) && par_mode && wr_q;

  //------------------------------------------------------------------
  // Timing mode select
  //------------------------------------------------------------------
  // The pin is sampled one edge after reset release, so it can share the pin with byte order.
  always_comb
  begin
    pend1_next = pend1_reg;
    pend2_next = pend2_reg;
    fwft1_next = fwft1_reg;
    fwft2_next = fwft2_reg;
    if (!first_fifo_full_reset_n)
      pend1_next = 1'b0;
    else if (rise1)
      pend1_next = 1'b1;
    else if (pend1_reg)
    begin
      pend1_next = 1'b0;
      fwft1_next = ~byte_order_timing_select;
    end
    if (!second_fifo_full_reset_n)
      pend2_next = 1'b0;
    else if (rise2)
      pend2_next = 1'b1;
    else if (pend2_reg && recv_clk_en)
    begin
      pend2_next = 1'b0;
      fwft2_next = ~byte_order_timing_select;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_fifo_full_reset_n_q_reg <= 1'b1; // Idle-high reset pins must not look like a rise.
      second_fifo_full_reset_n_q_reg <= 1'b1;
      pend1_reg  <= 1'b0;
      pend2_reg  <= 1'b0;
      fwft1_reg  <= 1'b0;
      fwft2_reg  <= 1'b0;
    end
    else
    begin
      first_fifo_full_reset_n_q_reg <= first_fifo_full_reset_n;
      second_fifo_full_reset_n_q_reg <= second_fifo_full_reset_n;
      pend1_reg  <= pend1_next;
      pend2_reg  <= pend2_next;
      fwft1_reg  <= fwft1_next;
      fwft2_reg  <= fwft2_next;
    end
  end

  //------------------------------------------------------------------
  // Offset loading
  //------------------------------------------------------------------
  // Offsets live in one vector ordered {y1, x1, y2, x2}, the serial and parallel order.
  always_comb
  begin
    method_next = method_reg;
    state_next  = state_reg;
    ofs_next    = ofs_reg;
    cnt_next    = cnt_reg;
    rdy1_next   = rdy1_reg;
    rdy2_next   = rdy2_reg;
    if (rise2)
      ofs_next[2*OFS_W-1:0] = pv[OFS_W] ? {2{pv[OFS_W-1:0]}} : '0;
    if (rise1)
    begin
      cnt_next = '0;
      if (pv[OFS_W])
        ofs_next[TOT_W-1:2*OFS_W] = {2{pv[OFS_W-1:0]}};
      method_next = cfo_pkg::CFO_M_PRESET;
      state_next  = cfo_pkg::CFO_S_RUN;
      if (rise2)
      begin
        case (sel)
          `CFO_SEL_SERIAL:
          begin
            method_next = cfo_pkg::CFO_M_SERIAL;
            state_next  = cfo_pkg::CFO_S_LOAD;
          end
          `CFO_SEL_PAR:
          begin
            method_next = cfo_pkg::CFO_M_PAR;
            state_next  = cfo_pkg::CFO_S_LOAD;
          end
          `CFO_SEL_PARIP:
          begin
            method_next = cfo_pkg::CFO_M_PARIP;
            state_next  = cfo_pkg::CFO_S_LOAD;
          end
          default:
            method_next = cfo_pkg::CFO_M_PRESET;
        endcase
      end
    end
    case (state_reg)
      cfo_pkg::CFO_S_LOAD:
      begin
        if (shift_en)
        begin
          ofs_next = {ofs_reg[TOT_W-2:0], flag_select0_serial_data};
          cnt_next = cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(TOT_W - 1))
          begin
            state_next = cfo_pkg::CFO_S_RUN;
          end
        end
        else if (offset_write_steal)
        begin
          case (cnt_reg[1:0])
            2'd0:    ofs_next[4*OFS_W-1:3*OFS_W] = par_word;
            2'd1:    ofs_next[3*OFS_W-1:2*OFS_W] = par_word;
            2'd2:    ofs_next[2*OFS_W-1:OFS_W]   = par_word;
            default: ofs_next[OFS_W-1:0]         = par_word;
          endcase
          cnt_next = cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(`CFO_NUM_OFS - 1))
          begin
            state_next = cfo_pkg::CFO_S_RUN;
          end
        end
      end
      cfo_pkg::CFO_S_RUN,
      cfo_pkg::CFO_S_RESET:
        state_next = state_next;
      default:
        state_next = cfo_pkg::CFO_S_RESET;
    endcase
    // Port A readiness: held during serial load, raised one edge after the last bit.
    if (!first_fifo_full_reset_n || rise1)
      rdy1_next = 1'b0;
    else if (state_reg == cfo_pkg::CFO_S_RUN)
      rdy1_next = 1'b1;
    else if (state_reg == cfo_pkg::CFO_S_LOAD && par_mode)
      rdy1_next = 1'b1;
    // Port C readiness waits for the load to end, then the next port C edge.
    if (!second_fifo_full_reset_n || rise1 || rise2)
      rdy2_next = 1'b0;
    else if (state_reg == cfo_pkg::CFO_S_RUN && recv_clk_en)
      rdy2_next = 1'b1;
    if (!first_fifo_full_reset_n)
      state_next = cfo_pkg::CFO_S_RESET;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      method_reg <= cfo_pkg::CFO_M_PRESET;
      state_reg  <= cfo_pkg::CFO_S_RESET;
      ofs_reg    <= '0;
      cnt_reg    <= '0;
      rdy1_reg   <= 1'b0;
      rdy2_reg   <= 1'b0;
    end
    else
    begin
      method_reg <= method_next;
      state_reg  <= state_next;
      ofs_reg    <= ofs_next;
      cnt_reg    <= cnt_next;
      rdy1_reg   <= rdy1_next;
      rdy2_reg   <= rdy2_next;
    end
  end

  //------------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------------
  // The four offsets feed the flag comparators of both FIFOs.
  assign port_a_almost_full_offset  = ofs_reg[4*OFS_W-1:3*OFS_W];
  assign port_b_almost_empty_offset = ofs_reg[3*OFS_W-1:2*OFS_W];
  assign port_c_almost_full_offset  = ofs_reg[2*OFS_W-1:OFS_W];
  assign port_a_almost_empty_offset = ofs_reg[OFS_W-1:0];
  // Flag style of each FIFO follows its fall-through bit: ready flags when set, empty/full when clear.
  assign mode.fall_through1            = fwft1_reg;
  assign mode.fall_through2            = fwft2_reg;
  assign mode.interleaved_parity_setup = (method_reg == cfo_pkg::CFO_M_PARIP);
  assign mode.serial_setup             = (method_reg == cfo_pkg::CFO_M_SERIAL);
  assign mode.parallel_setup           = par_mode;
  assign first_fifo_cfg_ready          = rdy1_reg;
  assign second_fifo_cfg_ready         = rdy2_reg;

  //------------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------------
  property p_fall_through_mode_select;
    @(posedge clk) disable iff (!rst_n)
    (pend1_reg && first_fifo_full_reset_n) |=> (fwft1_reg == !$past(byte_order_timing_select));
  endproperty
  a_fall_through_mode_select: assert property (p_fall_through_mode_select) else $error("Timing mode not taken from pin.");

  property p_preset64;
    @(posedge clk) disable iff (!rst_n)
    (rise1 && sel == `CFO_SEL_P64) |=> (port_a_almost_full_offset == OFS_W'(`CFO_VAL_P64))
      && (port_b_almost_empty_offset == OFS_W'(`CFO_VAL_P64));
  endproperty
  a_preset64: assert property (p_preset64) else $error("Preset 64 not loaded.");

  property p_serial_sel;
    @(posedge clk) disable iff (!rst_n)
    (rise1 && rise2 && sel == `CFO_SEL_SERIAL) |=> mode.serial_setup && state_reg == cfo_pkg::CFO_S_LOAD;
  endproperty
  a_serial_sel: assert property (p_serial_sel) else $error("Serial load not selected.");

  property p_par_sel;
    @(posedge clk) disable iff (!rst_n)
    (rise1 && rise2 && sel[1:0] == 2'b00) |=> mode.parallel_setup
      && (mode.interleaved_parity_setup == !$past(flag_select2));
  endproperty
  a_par_sel: assert property (p_par_sel) else $error("Parallel method wrong.");

  property p_par_first;
    @(posedge clk) disable iff (!rst_n)
    (offset_write_steal && cnt_reg == '0 && first_fifo_full_reset_n)
      |=> port_a_almost_full_offset == $past(par_word);
  endproperty
  a_par_first: assert property (p_par_first) else $error("First parallel write missed.");

  property p_steal_qual;
    @(posedge clk) disable iff (!rst_n)
    offset_write_steal |-> port_a_full_n && port_a_enable && port_a_write && !port_a_sel_n && !port_a_mailbox;
  endproperty
  a_steal_qual: assert property (p_steal_qual) else $error("Unqualified offset load.");

  property p_par_hold;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cfo_pkg::CFO_S_LOAD && par_mode && !rise2
      && !(!port_a_sel_n && port_a_write && port_a_enable && !port_a_mailbox && port_a_full_n)) |=> $stable(ofs_reg);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("Offset changed without a qualified write.");

  property p_ip_no_serial;
    @(posedge clk) disable iff (!rst_n)
    mode.interleaved_parity_setup |-> !shift_en && !mode.serial_setup;
  endproperty
  a_ip_no_serial: assert property (p_ip_no_serial) else $error("Serial load in parity mode.");

  property p_serial_bit;
    @(posedge clk) disable iff (!rst_n)
    (shift_en && first_fifo_full_reset_n) |=> port_a_almost_empty_offset[0] == $past(flag_select0_serial_data);
  endproperty
  a_serial_bit: assert property (p_serial_bit) else $error("Serial bit not shifted.");

  property p_serial_ready;
    @(posedge clk) disable iff (!rst_n)
    (shift_en && first_fifo_full_reset_n && cnt_reg == CNT_W'(TOT_W - 1)) ##1 first_fifo_full_reset_n
      |-> !first_fifo_cfg_ready ##1 first_fifo_cfg_ready;
  endproperty
  a_serial_ready: assert property (p_serial_ready) else $error("Port A ready timing wrong.");

  property p_load_hold;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == cfo_pkg::CFO_S_LOAD) |-> !second_fifo_cfg_ready;
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("Port C ready during load.");
endmodule : cfo_setup
`default_nettype wire

// ---- verif/cfo_host.sv ----
// Host controller model driving master resets, select pins and port A writes.
`timescale 1ns/10ps
`default_nettype none
module cfo_host (
  // Clock and port A input flag from the device.
  input  wire logic   clk,
  input  wire logic   full_n,
  // Master resets, timing pin and select pins.
  output logic        first_fifo_full_reset_n_n,
  output logic        second_fifo_full_reset_n_n,
  output logic        tsel,
  output logic        fs2,
  output logic        fs1,
  output logic        fs0,
  // Port A write controls and data.
  output logic        sel_n,
  output logic        wr,
  output logic        en,
  output logic [35:0] data
);
  // Idle levels; select pins start high so no serial shift is requested.
  initial
  begin
    {first_fifo_full_reset_n_n, second_fifo_full_reset_n_n, tsel, fs2, fs1, fs0} = 6'h3F;
    {sel_n, wr, en} = 3'h4;
    data = 36'h0;
  end

  // Every change lands one nanosecond after a rising edge.
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // Both resets pulse together; the timing pin then stays put until the next one.
  task automatic mreset(input logic [2:0] code, input logic tpin);
    first_fifo_full_reset_n_n = 1'h0;
    second_fifo_full_reset_n_n = 1'h0;
    tsel = tpin;
    {fs2, fs1, fs0} = code;
    repeat (8) step();
    first_fifo_full_reset_n_n = 1'h1;
    second_fifo_full_reset_n_n = 1'h1;
    step();
    {fs1, fs0} = (code[1:0] == 2'h0) ? 2'h0 : 2'h3;
  endtask : mreset

  // Shift MSB first, with random idle gaps while the enable is high.
  task automatic serial_load(input logic [51:0] v);
    for (int i = 51; i >= 0; i--)
    begin
      if ($urandom % 4 == 0)
      begin
        fs1 = 1'h1;
        step();
      end
      fs0 = v[i];
      fs1 = 1'h0;
      step();
    end
    fs1 = 1'h1;
    fs0 = ~fs0;
  endtask : serial_load

  // A qualified write waits for the input flag; a released bus shows inverted data.
  task automatic par_write(input logic [35:0] d, input logic qual);
    while (qual && !full_n) step();
    {sel_n, wr, en, data} = {~qual, 2'h3, d};
    step();
    {sel_n, en, data} = {2'h2, ~d};
    step(); // Lets an edge pass so back-to-back writes never re-assign the strobes in one time step.
  endtask : par_write
endmodule : cfo_host
`default_nettype wire

// ---- verif/cfo_setup_tb.sv ----
// Self-checking testbench for the timing-mode and flag-offset setup block.
`timescale 1ns/10ps
`default_nettype none
`include "cfo_cfg.svh"
module cfo_setup_tb;
  typedef struct packed {logic [51:0] ofs; logic [3:0] md;} cfo_note_t;
  logic               clk;
  logic               rst_n;
  logic               rce;
  logic               first_fifo_full_reset_n_n, second_fifo_full_reset_n_n, tsel, fs2, fs1, fs0, sel_n, wr, en;
  logic [35:0]        data;
  logic [12:0]        y1, x1, y2, x2;
  cfo_pkg::cfo_mode_t mode;
  logic               rdy1, rdy2, steal, t;
  logic               rdy2_q = 1'h0;
  logic               mb = 1'h0;
  logic [3:0]         steals = 4'h0;
  logic [12:0]        ov [4];
  logic [35:0]        d;
  cfo_note_t          notes [$];
  cfo_note_t          n;
  int                 errors = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  logic [2:0]         codes [5] = '{`CFO_SEL_P64, `CFO_SEL_P16, `CFO_SEL_P8, `CFO_SEL_P256, `CFO_SEL_P1024};
  int                 vals [5] = '{`CFO_VAL_P64, `CFO_VAL_P16, `CFO_VAL_P8, `CFO_VAL_P256, `CFO_VAL_P1024};

  //----------------------------------------------------------------
  // Design, host model and clock
  //----------------------------------------------------------------
  cfo_setup uut (.clk(clk), .rst_n(rst_n), .recv_clk_en(rce), .first_fifo_full_reset_n(first_fifo_full_reset_n_n),
    .second_fifo_full_reset_n(second_fifo_full_reset_n_n), .byte_order_timing_select(tsel), .flag_select2(fs2),
    .flag_select1_serial_enable_n(fs1), .flag_select0_serial_data(fs0), .port_a_sel_n(sel_n),
    .port_a_write(wr), .port_a_enable(en), .port_a_mailbox(mb), .port_a_full_n(rdy1),
    .port_a_data(data), .port_b_almost_empty_offset(x1), .port_a_almost_full_offset(y1),
    .port_a_almost_empty_offset(x2), .port_c_almost_full_offset(y2), .mode(mode),
    .first_fifo_cfg_ready(rdy1), .second_fifo_cfg_ready(rdy2), .offset_write_steal(steal));
  cfo_host host (.clk(clk), .full_n(rdy1), .first_fifo_full_reset_n_n(first_fifo_full_reset_n_n), .second_fifo_full_reset_n_n(second_fifo_full_reset_n_n), .tsel(tsel), .fs2(fs2),
    .fs1(fs1), .fs0(fs0), .sel_n(sel_n), .wr(wr), .en(en), .data(data));

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Port C edges arrive at random, so second-FIFO sampling moves from one reset to the next.
  always @(posedge clk) #1 rce = ($urandom % 3 == 0);

  //----------------------------------------------------------------
  // Comparison, monitor and closing
  //----------------------------------------------------------------
  task automatic cmp_ofs(input string what, input logic [51:0] exp, input logic [51:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_ofs

  task automatic cmp_flag(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_flag

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // The oldest note is judged when the second FIFO becomes ready; steals are counted per reset.
  always @(posedge clk)
  begin
    rdy2_q <= rdy2;
    steals <= !first_fifo_full_reset_n_n ? 4'h0 : steals + {3'h0, steal};
    if (rst_n && rdy2 === 1'h1 && rdy2_q === 1'h0)
    begin
      n = notes.pop_front();
      cmp_ofs("offsets", n.ofs, {y1, x1, y2, x2});
      cmp_flag("mode", n.md, mode[4:1]);
    end
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  // Waits, bounded, until every note has been judged.
  task automatic drain();
    for (int k = 0; k < 80 && notes.size() != 0; k++) host.step();
  endtask : drain

  //----------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------
  initial
  begin
    void'($urandom(78));
    rst_n = 1'h0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'h1;
    host.step();
    cmp_ofs("reset offsets", 52'h0, {y1, x1, y2, x2});
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      t = 1'($urandom % 2);
      notes.push_back('{{4{13'(vals[i])}}, {~t, ~t, 2'h0}});
      host.mreset(codes[i], t);
      drain();
    end
    $display("test presets done");
    t = 1'($urandom % 2);
    for (int i = 0; i < 4; i++) ov[i] = 13'(1 + $urandom % 8188);
    notes.push_back('{{ov[0], ov[1], ov[2], ov[3]}, {~t, ~t, 2'h1}});
    host.mreset(`CFO_SEL_SERIAL, t);
    host.serial_load({ov[0], ov[1], ov[2], ov[3]});
    cmp_flag("ready at last bit", 4'h0, {3'h0, rdy1});
    host.step();
    cmp_flag("ready after last bit", 4'h1, {3'h0, rdy1});
    drain();
    $display("test serial done");
    for (int ip = 0; ip < 2; ip++)
    begin
      t = 1'($urandom % 2);
      for (int i = 0; i < 4; i++) ov[i] = 13'(1 + $urandom % 8188);
      notes.push_back('{{ov[0], ov[1], ov[2], ov[3]}, {~t, ~t, ip[0], 1'h0}});
      host.mreset(ip[0] ? `CFO_SEL_PARIP : `CFO_SEL_PAR, t);
      repeat (3) host.step();
      host.par_write(36'({$urandom, $urandom}), 1'h0);
      // A mailbox write is otherwise qualified but must not load an offset.
      mb = 1'h1;
      host.par_write(36'({$urandom, $urandom}), 1'h1);
      mb = 1'h0;
      for (int i = 0; i < 5; i++)
      begin
        d = 36'({$urandom, $urandom});
        if (ip[0])
          {d[13:9], d[7:0]} = ov[i % 4];
        else
          d[12:0] = ov[i % 4];
        host.par_write(d, 1'h1);
      end
      drain();
      repeat (2) host.step();
      cmp_flag("stolen writes", 4'h4, steals);
      cmp_flag("parallel mode", 4'h1, {3'h0, mode.parallel_setup});
    end
    $display("test parallel done");
    cmp_flag("notes left", 4'h0, 4'(notes.size()));
    finish_test();
  end
endmodule : cfo_setup_tb
`default_nettype wire
